// ===== pirq_pkg.sv
// Purpose: shared constants and carriers for the peripheral interrupt flag/enable/priority block
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes: all offsets are byte addresses
package pirq_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] PIRQ_OFS_FLAGS_ONE = 8'h00;
   localparam logic [7:0] PIRQ_OFS_FLAGS_TWO = 8'h04;
   localparam logic [7:0] PIRQ_OFS_ENABLES_ONE = 8'h08;
   localparam logic [7:0] PIRQ_OFS_ENABLES_TWO = 8'h0C;
   localparam logic [7:0] PIRQ_OFS_PRIORITY_ONE = 8'h10;
   localparam logic [7:0] PIRQ_OFS_PRIORITY_TWO = 8'h14;
   localparam logic [7:0] PIRQ_OFS_CONTROL = 8'h18;
   localparam logic [7:0] PIRQ_OFS_STATUS = 8'h1C;
   // ==========================================
   // reset values and masks
   localparam logic [7:0] PIRQ_FLAG_RESET = 8'h00;
   localparam logic [7:0] PIRQ_ENABLE_RESET = 8'h00;
   localparam logic [7:0] PIRQ_PRIORITY_RESET = 8'hFF;
   localparam logic [7:0] PIRQ_TWO_MASK = 8'hDF;
   localparam logic [7:0] PIRQ_PARPORT_MASK = 8'h7F;
   localparam logic [7:0] PIRQ_ALL_MASK = 8'hFF;
   // flags one: receive and transmit flags are read-only, owned by the serial port
   localparam logic [7:0] PIRQ_ONE_SW_MASK = 8'hCF;
   localparam logic [7:0] PIRQ_ONE_HW_MASK = 8'h30;
   // ==========================================
   // field positions
   localparam int PIRQ_BIT_CAPTURE_COMPARE_ONE = 2;
   localparam int PIRQ_BIT_TIMER2_COUNT = 1;
   localparam int PIRQ_BIT_TIMER1_COUNT = 0;
   localparam int PIRQ_BIT_OSCF = 7;
   localparam int PIRQ_BIT_CMP = 6;
   localparam int PIRQ_BIT_MEMW = 4;
   localparam int PIRQ_BIT_BCOL = 3;
   localparam int PIRQ_BIT_VDET = 2;
   localparam int PIRQ_BIT_TIMER3_COUNT = 1;
   localparam int PIRQ_BIT_CAPTURE_COMPARE_TWO = 0;
   localparam int PIRQ_CTL_PRIO_ON = 0;
   localparam int PIRQ_CTL_GATE_HIGH = 1;
   localparam int PIRQ_CTL_GATE_LOW = 2;
   localparam int PIRQ_CTL_VDIR = 3;
   localparam logic [3:0] PIRQ_CTL_MASK = 4'hF;
   localparam logic [1:0] PIRQ_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIRQ_RESP_SLVERR = 2'h2;

   // capture/compare unit mode
   typedef enum logic [1:0] {
      PIRQ_CC_CAPTURE = 2'b00,
      PIRQ_CC_COMPARE = 2'b01,
      PIRQ_CC_PWM = 2'b10,
      PIRQ_CC_OFF = 2'b11
   } pirq_cc_mode_t;

   // peripheral event pulses, one cycle each
   typedef struct packed {
      logic parport_rw;
      logic converter_done;
      logic sync_serial_done;
      logic cc1_capture;
      logic cc1_compare;
      logic timer2_match;
      logic timer1_overflow;
      logic osc_failure;
      logic comparator_change;
      logic memory_write_done;
      logic bus_collision;
      logic voltage_rise;
      logic voltage_fall;
      logic timer3_overflow;
      logic cc2_capture;
      logic cc2_compare;
   } pirq_events_t;

   // serial port level flags
   typedef struct packed {
      logic receive_full;
      logic transmit_empty;
   } pirq_serial_t;
endpackage : pirq_pkg

// ===== pirq_flag_cell.sv
// Purpose: eight sticky request flags with software load
// Assumes: one clock, synchronous active-low reset
// Notes: hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
module pirq_flag_cell #(
   parameter logic [7:0] IMPL_MASK = 8'hFF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] set_bits,
   input wire logic sw_wr,
   input wire logic [7:0] sw_data,
   output logic [7:0] flags
);
   logic [7:0] flags_reg;
   logic [7:0] flags_next;

   assign flags_next = ((sw_wr ? sw_data : flags_reg) | set_bits) & IMPL_MASK;
   assign flags = flags_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_reg <= pirq_pkg::PIRQ_FLAG_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   a_set_not_lost: assert property (@(posedge aclk) disable iff (!aresetn)
      (|(set_bits & IMPL_MASK)) |=> ((flags_reg & $past(set_bits) & IMPL_MASK) == ($past(set_bits) & IMPL_MASK)))
      else $error("flag set lost");
endmodule : pirq_flag_cell

// ===== pirq_irq_ctrl.sv
// Purpose: peripheral interrupt flags, enables and priorities behind axi4-lite
// Assumes: aclk 40 MHz, synchronous active-low aresetn, master keeps one write and one read outstanding
// Notes: requests to the core are levels from flip-flops
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module pirq_irq_ctrl #(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pirq_pkg::pirq_events_t events,
   input wire pirq_pkg::pirq_serial_t serial_state,
   input wire pirq_pkg::pirq_cc_mode_t cc1_mode,
   input wire pirq_pkg::pirq_cc_mode_t cc2_mode,
   output logic irq_high,
   output logic irq_low
);
   localparam logic [7:0] ONE_MASK = SMALL_PACKAGE ? pirq_pkg::PIRQ_PARPORT_MASK : pirq_pkg::PIRQ_ALL_MASK;

   function automatic logic [7:0] pirq_lane0(input logic [31:0] d, input logic [3:0] s, input logic [7:0] old);
      pirq_lane0 = s[0] ? d[7:0] : old;
   endfunction : pirq_lane0

   // ==========================================
   // write channel
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic awready_reg;
   logic wready_reg;
   wire aw_fire = s_axi_awvalid && awready_reg;
   wire w_fire = s_axi_wvalid && wready_reg;
   wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
   wire [7:0] wa = awaddr_reg;
   wire wr_flags1 = wr_go && (wa == pirq_pkg::PIRQ_OFS_FLAGS_ONE) && wstrb_reg[0];
   wire wr_flags2 = wr_go && (wa == pirq_pkg::PIRQ_OFS_FLAGS_TWO) && wstrb_reg[0];
   wire wr_en1 = wr_go && (wa == pirq_pkg::PIRQ_OFS_ENABLES_ONE);
   wire wr_en2 = wr_go && (wa == pirq_pkg::PIRQ_OFS_ENABLES_TWO);
   wire wr_pr1 = wr_go && (wa == pirq_pkg::PIRQ_OFS_PRIORITY_ONE);
   wire wr_pr2 = wr_go && (wa == pirq_pkg::PIRQ_OFS_PRIORITY_TWO);
   wire wr_ctl = wr_go && (wa == pirq_pkg::PIRQ_OFS_CONTROL);
   wire wa_known = (wa == pirq_pkg::PIRQ_OFS_FLAGS_ONE) || (wa == pirq_pkg::PIRQ_OFS_FLAGS_TWO)
      || (wa == pirq_pkg::PIRQ_OFS_ENABLES_ONE) || (wa == pirq_pkg::PIRQ_OFS_ENABLES_TWO)
      || (wa == pirq_pkg::PIRQ_OFS_PRIORITY_ONE) || (wa == pirq_pkg::PIRQ_OFS_PRIORITY_TWO)
      || (wa == pirq_pkg::PIRQ_OFS_CONTROL) || (wa == pirq_pkg::PIRQ_OFS_STATUS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= pirq_pkg::PIRQ_RESP_OKAY;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else begin
         awready_reg <= !aw_held_reg && !aw_fire && !bvalid_reg;
         wready_reg <= !w_held_reg && !w_fire && !bvalid_reg;
         if (aw_fire) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wa_known ? pirq_pkg::PIRQ_RESP_OKAY : pirq_pkg::PIRQ_RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   // ==========================================
   // enables, priorities, control
   logic [7:0] en1_reg;
   logic [7:0] en2_reg;
   logic [7:0] pr1_reg;
   logic [7:0] pr2_reg;
   logic [3:0] ctl_reg;
   wire [7:0] wbyte = wdata_reg[7:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en1_reg <= pirq_pkg::PIRQ_ENABLE_RESET;
         en2_reg <= pirq_pkg::PIRQ_ENABLE_RESET;
         pr1_reg <= pirq_pkg::PIRQ_PRIORITY_RESET & ONE_MASK;
         pr2_reg <= pirq_pkg::PIRQ_PRIORITY_RESET & pirq_pkg::PIRQ_TWO_MASK;
         ctl_reg <= 4'h0;
      end else begin
         // enable one, parallel port bit absent on small package
         if (wr_en1) begin
            en1_reg <= pirq_lane0(wdata_reg, wstrb_reg, en1_reg) & ONE_MASK;
         end
         // enable two, bit 5 kept zero
         if (wr_en2) begin
            en2_reg <= pirq_lane0(wdata_reg, wstrb_reg, en2_reg) & pirq_pkg::PIRQ_TWO_MASK;
         end
         if (wr_pr1) begin
            pr1_reg <= pirq_lane0(wdata_reg, wstrb_reg, pr1_reg) & ONE_MASK;
         end
         if (wr_pr2) begin
            pr2_reg <= pirq_lane0(wdata_reg, wstrb_reg, pr2_reg) & pirq_pkg::PIRQ_TWO_MASK;
         end
         if (wr_ctl && wstrb_reg[0]) begin
            ctl_reg <= wbyte[3:0] & pirq_pkg::PIRQ_CTL_MASK;
         end
      end
   end

   // ==========================================
   // flag setting
   wire prio_on = ctl_reg[pirq_pkg::PIRQ_CTL_PRIO_ON];
   wire gate_high = ctl_reg[pirq_pkg::PIRQ_CTL_GATE_HIGH];
   wire gate_low = ctl_reg[pirq_pkg::PIRQ_CTL_GATE_LOW];
   wire vdir_up = ctl_reg[pirq_pkg::PIRQ_CTL_VDIR];
   // unit one: compare in compare mode, capture in capture mode; nothing in pwm
   wire cc1_set = (cc1_mode == pirq_pkg::PIRQ_CC_COMPARE) && events.cc1_compare
      || (cc1_mode == pirq_pkg::PIRQ_CC_CAPTURE) && events.cc1_capture;
   // pwm mode leaves the flag untouched
   wire cc2_set = (cc2_mode == pirq_pkg::PIRQ_CC_CAPTURE) && events.cc2_capture
      || (cc2_mode == pirq_pkg::PIRQ_CC_COMPARE) && events.cc2_compare;
   // direction picked by the control bit
   wire vdet_set = vdir_up ? events.voltage_rise : events.voltage_fall;
   wire [7:0] set1;
   wire [7:0] set2;
   assign set1 = {events.parport_rw, events.converter_done, 2'h0, events.sync_serial_done,
      cc1_set, events.timer2_match, events.timer1_overflow} & ONE_MASK;
   assign set2 = {events.osc_failure, events.comparator_change, 1'h0, events.memory_write_done,
      events.bus_collision, vdet_set, events.timer3_overflow, cc2_set};

   logic [7:0] flags1_sw;
   logic [7:0] flags2;
   pirq_flag_cell #(
      .IMPL_MASK(pirq_pkg::PIRQ_ONE_SW_MASK & ONE_MASK)
   ) u_flags_one (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_bits(set1),
      .sw_wr(wr_flags1),
      .sw_data(wbyte),
      .flags(flags1_sw)
   );
   pirq_flag_cell #(
      .IMPL_MASK(pirq_pkg::PIRQ_TWO_MASK)
   ) u_flags_two (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_bits(set2),
      .sw_wr(wr_flags2),
      .sw_data(wbyte),
      .flags(flags2)
   );
   // serial flags follow the port's own buffer state, software cannot clear them
   wire [7:0] flags1 = flags1_sw | ({2'h0, serial_state.receive_full, serial_state.transmit_empty, 4'h0} &
      pirq_pkg::PIRQ_ONE_HW_MASK);

   // ==========================================
   // request combining
   wire [7:0] act1 = flags1 & en1_reg;
   wire [7:0] act2 = flags2 & en2_reg;
   wire any_act = |{act1, act2};
   wire any_high = |{act1 & pr1_reg, act2 & pr2_reg};
   wire any_low = |{act1 & ~pr1_reg, act2 & ~pr2_reg};
   wire req_high;
   wire req_low;
   // level mode select, single level needs both gates, high level needs gate_high, low level needs both gates, request
   assign req_high = prio_on ? (any_high && gate_high) : (any_act && gate_high && gate_low);
   assign req_low = prio_on && any_low && gate_high && gate_low;

   logic irq_high_reg;
   logic irq_low_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_high_reg <= 1'b0;
         irq_low_reg <= 1'b0;
      end else begin
         irq_high_reg <= req_high;
         irq_low_reg <= req_low;
      end
   end
   assign irq_high = irq_high_reg;
   assign irq_low = irq_low_reg;

   // ==========================================
   // read channel
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   wire ar_fire = s_axi_arvalid && arready_reg;
   wire [7:0] ra = s_axi_araddr;
   logic [7:0] rbyte;
   logic r_known;
   always_comb begin
      rbyte = 8'h00;
      r_known = 1'b1;
      unique case (ra)
         pirq_pkg::PIRQ_OFS_FLAGS_ONE: rbyte = flags1;
         pirq_pkg::PIRQ_OFS_FLAGS_TWO: rbyte = flags2;
         pirq_pkg::PIRQ_OFS_ENABLES_ONE: rbyte = en1_reg;
         pirq_pkg::PIRQ_OFS_ENABLES_TWO: rbyte = en2_reg;
         pirq_pkg::PIRQ_OFS_PRIORITY_ONE: rbyte = pr1_reg;
         pirq_pkg::PIRQ_OFS_PRIORITY_TWO: rbyte = pr2_reg;
         pirq_pkg::PIRQ_OFS_CONTROL: rbyte = {4'h0, ctl_reg};
         pirq_pkg::PIRQ_OFS_STATUS: rbyte = {6'h00, irq_low_reg, irq_high_reg};
         default: r_known = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= pirq_pkg::PIRQ_RESP_OKAY;
      end else begin
         arready_reg <= !rvalid_reg && !ar_fire;
         if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rbyte};
            rresp_reg <= r_known ? pirq_pkg::PIRQ_RESP_OKAY : pirq_pkg::PIRQ_RESP_SLVERR;
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ==========================================
   // checks
   // bit five stays zero
   a_bit5_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      ((flags2 | en2_reg | pr2_reg) & ~pirq_pkg::PIRQ_TWO_MASK) == 8'h00)
      else $error("bit five set");
   a_single_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      (!prio_on && !gate_low) |=> !irq_high_reg)
      else $error("request without peripheral gate");
   a_low_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_low_reg |-> $past(gate_low) && $past(gate_high) && $past(prio_on))
      else $error("low request gated");
   a_req_raise: assert property (@(posedge aclk) disable iff (!aresetn)
      (prio_on && gate_high && |{act1 & pr1_reg, act2 & pr2_reg}) |=> irq_high_reg)
      else $error("high request missing");
   // no low level in single mode
   a_no_low_single: assert property (@(posedge aclk) disable iff (!aresetn)
      !prio_on ##1 !prio_on |-> !irq_low_reg)
      else $error("low request in single mode");
   a_osc_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.osc_failure |=> flags2[pirq_pkg::PIRQ_BIT_OSCF])
      else $error("osc flag not set");
   a_cmp_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.comparator_change |=> flags2[pirq_pkg::PIRQ_BIT_CMP])
      else $error("comparator flag not set");
   a_memw_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.memory_write_done |=> flags2[pirq_pkg::PIRQ_BIT_MEMW])
      else $error("memory write flag not set");
   a_t3_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.timer3_overflow |=> flags2[pirq_pkg::PIRQ_BIT_TIMER3_COUNT])
      else $error("timer3 flag not set");
   a_vdet_dir: assert property (@(posedge aclk) disable iff (!aresetn)
      (!vdir_up && events.voltage_rise && !events.voltage_fall && !flags2[pirq_pkg::PIRQ_BIT_VDET] && !wr_flags2)
      |=> !flags2[pirq_pkg::PIRQ_BIT_VDET])
      else $error("voltage flag set on wrong direction");
   a_cc2_pwm: assert property (@(posedge aclk) disable iff (!aresetn)
      (cc2_mode == pirq_pkg::PIRQ_CC_PWM && !flags2[pirq_pkg::PIRQ_BIT_CAPTURE_COMPARE_TWO] && !wr_flags2)
      |=> !flags2[pirq_pkg::PIRQ_BIT_CAPTURE_COMPARE_TWO])
      else $error("unit two flag set in pwm");
   // pwm mode leaves unit one alone
   a_cc1_pwm: assert property (@(posedge aclk) disable iff (!aresetn)
      (cc1_mode == pirq_pkg::PIRQ_CC_PWM && !flags1[pirq_pkg::PIRQ_BIT_CAPTURE_COMPARE_ONE] && !wr_flags1)
      |=> !flags1[pirq_pkg::PIRQ_BIT_CAPTURE_COMPARE_ONE])
      else $error("unit one flag set in pwm");
   a_t2_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.timer2_match |=> flags1[pirq_pkg::PIRQ_BIT_TIMER2_COUNT])
      else $error("timer2 flag not set");
   a_t1_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      events.timer1_overflow |=> flags1[pirq_pkg::PIRQ_BIT_TIMER1_COUNT])
      else $error("timer1 flag not set");
   a_small_pkg: assert property (@(posedge aclk) disable iff (!aresetn)
      ((flags1 | en1_reg | pr1_reg) & ~ONE_MASK) == 8'h00)
      else $error("parallel bit on small package");
   a_sw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_flags2 && !wbyte[pirq_pkg::PIRQ_BIT_TIMER3_COUNT] && !set2[pirq_pkg::PIRQ_BIT_TIMER3_COUNT])
      |=> !flags2[pirq_pkg::PIRQ_BIT_TIMER3_COUNT])
      else $error("flag not cleared");
endmodule : pirq_irq_ctrl

// ===== pirq_core_model.sv
// Purpose: core-side model that takes level requests from the interrupt block
// Assumes: requests are levels that stand until software clears the source
// Notes: LATENCY sets how long a request must stand before the core takes it
`timescale 1ns/1ps
module pirq_core_model #(
   parameter int LATENCY = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_high,
   input wire logic irq_low,
   output logic taken_high,
   output logic taken_low
);
   int hi_cnt;
   int lo_cnt;
   // ==========================================
   // request taking
   // taken once standing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_cnt <= 0;
         lo_cnt <= 0;
         taken_high <= 1'h0;
         taken_low <= 1'h0;
      end else begin
         hi_cnt <= irq_high ? hi_cnt + 1 : 0;
         lo_cnt <= irq_low ? lo_cnt + 1 : 0;
         if (hi_cnt >= LATENCY) taken_high <= 1'h1;
         if (lo_cnt >= LATENCY) taken_low <= 1'h1;
      end
   end
endmodule : pirq_core_model

// ===== test_pirq_irq_ctrl.sv
// Purpose: self-checking bench for the peripheral interrupt flag block
// Assumes: byte offsets from the package, data in bits 7:0
// Notes: events are one-cycle pulses; sticky taken flags come from the core model
`timescale 1ns/1ps
module test_pirq_irq_ctrl;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr;
   logic awvalid;
   logic awready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wvalid;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready;
   logic [7:0] araddr;
   logic arvalid;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready;
   logic [15:0] ev;
   logic [1:0] serial;
   pirq_pkg::pirq_cc_mode_t cc1_mode;
   pirq_pkg::pirq_cc_mode_t cc2_mode;
   logic irq_high;
   logic irq_low;
   logic taken_high;
   logic taken_low;
   int bad_count = 0;
   int checks = 0;
   int cycles = 0;
   int ev_bit[9] = '{8, 7, 6, 5, 4, 3, 2, 1, 0};
   logic [7:0] ev_exp[9] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h00, 8'h02, 8'h01, 8'h00};
   logic [7:0] ctl_tab[7] = '{8'h02, 8'h06, 8'h03, 8'h03, 8'h07, 8'h05, 8'h05};
   logic [7:0] pri_tab[7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFE, 8'hFE, 8'hFF};
   logic [1:0] irq_tab[7] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};

   pirq_irq_ctrl #(.SMALL_PACKAGE(1'h0)) i_pirq_irq_ctrl (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .events(pirq_pkg::pirq_events_t'(ev)), .serial_state(pirq_pkg::pirq_serial_t'(serial)),
      .cc1_mode(cc1_mode), .cc2_mode(cc2_mode), .irq_high(irq_high), .irq_low(irq_low));

   pirq_core_model #(.LATENCY(2)) i_pirq_core_model (.aclk(aclk), .aresetn(aresetn), .irq_high(irq_high),
      .irq_low(irq_low), .taken_high(taken_high), .taken_low(taken_low));

   // ==========================================
   // clock and hang guard
   initial begin
      aclk = 1'h0;
      forever #12.5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ==========================================
   // bus and event tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = pirq_pkg::PIRQ_RESP_OKAY);
      logic done;
      done = 1'h0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) begin
            done = 1'h1;
            bready <= 1'h0;
            chk("bresp", {30'h0, er}, {30'h0, bresp});
         end
      end
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = pirq_pkg::PIRQ_RESP_OKAY);
      logic done;
      done = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) begin
            done = 1'h1;
            rready <= 1'h0;
            chk($sformatf("rdata %h", a), {24'h0, e}, rdata);
            chk("rresp", {30'h0, er}, {30'h0, rresp});
         end
      end
      @(posedge aclk);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask : idle

   task automatic pulse(input int b);
      ev[b] <= 1'h1;
      @(posedge aclk);
      ev <= 16'h0000;
      idle(2);
   endtask : pulse

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   // ==========================================
   // main sequence
   initial begin
      aresetn = 1'h0;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'h1;
      ev = 16'h0000;
      serial = 2'h0;
      cc1_mode = pirq_pkg::PIRQ_CC_COMPARE;
      cc2_mode = pirq_pkg::PIRQ_CC_CAPTURE;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_ONE, 8'h00);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
      rd(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'h00);
      rd(pirq_pkg::PIRQ_OFS_ENABLES_TWO, 8'h00);
      rd(pirq_pkg::PIRQ_OFS_PRIORITY_ONE, 8'hFF);
      rd(pirq_pkg::PIRQ_OFS_PRIORITY_TWO, 8'hDF);
      wr(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'hA5);
      rd(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'hA5);
      wr(pirq_pkg::PIRQ_OFS_ENABLES_TWO, 8'hFF);
      rd(pirq_pkg::PIRQ_OFS_ENABLES_TWO, 8'hDF);
      wr(pirq_pkg::PIRQ_OFS_PRIORITY_TWO, 8'h20);
      rd(pirq_pkg::PIRQ_OFS_PRIORITY_TWO, 8'h00);
      wr(pirq_pkg::PIRQ_OFS_ENABLES_TWO, 8'h00);
      wr(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'h00);
      // lane zero strobe off: write accepted but ignored
      wstrb <= 4'hE;
      wr(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'hFF);
      wstrb <= 4'h1;
      rd(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'h00);
      wr(8'h20, 8'hFF, pirq_pkg::PIRQ_RESP_SLVERR);
      rd(8'h20, 8'h00, pirq_pkg::PIRQ_RESP_SLVERR);
      // rising trip selected; all enables off so flags are polled
      wr(pirq_pkg::PIRQ_OFS_CONTROL, 8'h08);
      for (int i = 0; i < 9; i++) begin
         pulse(ev_bit[i]);
         rd(pirq_pkg::PIRQ_OFS_FLAGS_TWO, ev_exp[i]);
         wr(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
      end
      wr(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'hFF);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'hDF);
      wr(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
      wr(pirq_pkg::PIRQ_OFS_CONTROL, 8'h00);
      pulse(4);
      pulse(3);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h04);
      wr(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
      cc2_mode <= pirq_pkg::PIRQ_CC_COMPARE;
      pulse(1);
      pulse(0);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h01);
      wr(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
      cc2_mode <= pirq_pkg::PIRQ_CC_PWM;
      pulse(1);
      pulse(0);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
      // timer3 event on the very edge that applies the clearing write
      fork
         wr(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
         begin
            idle(1);
            ev[2] <= 1'h1;
            idle(1);
            ev <= 16'h0000;
         end
      join
      rd(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h02);
      wr(pirq_pkg::PIRQ_OFS_FLAGS_TWO, 8'h00);
      pulse(9);
      pulse(10);
      pulse(11);
      pulse(12);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_ONE, 8'h07);
      wr(pirq_pkg::PIRQ_OFS_FLAGS_ONE, 8'h00);
      cc1_mode <= pirq_pkg::PIRQ_CC_PWM;
      serial <= 2'h2;
      pulse(11);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_ONE, 8'h20);
      serial <= 2'h1;
      cc1_mode <= pirq_pkg::PIRQ_CC_CAPTURE;
      pulse(11);
      pulse(12);
      rd(pirq_pkg::PIRQ_OFS_FLAGS_ONE, 8'h14);
      serial <= 2'h0;
      wr(pirq_pkg::PIRQ_OFS_FLAGS_ONE, 8'h00);
      wr(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'h01);
      pulse(9);
      for (int i = 0; i < 7; i++) begin
         wr(pirq_pkg::PIRQ_OFS_PRIORITY_ONE, pri_tab[i]);
         wr(pirq_pkg::PIRQ_OFS_CONTROL, ctl_tab[i]);
         idle(2);
         chk("irq", {30'h0, irq_tab[i]}, {30'h0, irq_high, irq_low});
         rd(pirq_pkg::PIRQ_OFS_PRIORITY_ONE, pri_tab[i]);
         rd(pirq_pkg::PIRQ_OFS_CONTROL, ctl_tab[i]);
         rd(pirq_pkg::PIRQ_OFS_STATUS, {6'h00, irq_tab[i][0], irq_tab[i][1]});
      end
      chk("taken", 32'h3, {30'h0, taken_high, taken_low});
      wr(pirq_pkg::PIRQ_OFS_CONTROL, 8'h06);
      wr(pirq_pkg::PIRQ_OFS_ENABLES_ONE, 8'h00);
      idle(2);
      chk("irq off", 32'h0, {30'h0, irq_high, irq_low});
      report_and_stop();
   end
endmodule : test_pirq_irq_ctrl
